//--- src/mode_selected_port_config.v
// Three GPIO ports with selector-steered configuration writes.
// Assumes a CPU core on i_clk issuing one-cycle strobes.
// Function
// RL1 - Port A has four pins, B and C eight, each pin configurable.
// RL2 - Port A uses low nibble only; bit zero maps to pin zero.
// RL3 - Configuration registers reset to all ones.
// RL4 - Port data registers at consecutive data addresses A, B, C.
// RL5 - Data writes drive levels on pins configured as output.
// RL6 - Writes to input pins still load the latch for later use.
// RL7 - Data reads return sampled pin levels, not latch contents.
// RL8 - Output driven high but held low reads back low.
// RL9 - Software inserts an idle instruction between bit read-modify-writes.
// RL10 - Per-port control write moves working register to selected config.
// RL11 - Selector is not memory mapped; loaded and read by own strobes.
// RL12 - Software keeps selector between 08h and 0Fh.
// RL13 - Selector resets to 0Fh, selecting direction registers.
// RL14 - Selector value holds until written again.
// RL15 - Selector decode 08h to 0Fh as per port table.
// RL16 - Pullup bit one disconnects pullup, zero connects.
// RL17 - Direction bit one is high-impedance input, zero drives output.
// RL18 - Threshold bit zero senses CMOS, one senses TTL.
// RL19 - Hysteresis option only on ports B and C; B carries wake pins.
// RL20 - Hysteresis bit zero enables Schmitt input, one disables.
// RL21 - Wake-enable bit zero enables edge detection on pin.
// RL22 - Wake-edge bit zero rising, one falling.
// RL23 - Wake-pending bit reads one after a valid enabled edge.
// RL24 - Control write to an unused selector slot changes nothing.
`timescale 1ns/1ps
`include "port_cfg_regs.vh"
module mode_selected_port_config #(
  parameter A_W = 4,
  parameter B_W = 8,
  parameter C_W = 8
) (
  input  wire           i_clk,
  input  wire           i_rst,
  input  wire [4:0]     i_addr,
  input  wire           i_wr,
  input  wire           i_rd,
  input  wire [7:0]     i_wdata,
  output reg  [7:0]     o_rdata,
  input  wire           i_sel_wr,
  input  wire [7:0]     i_sel_wdata,
  output wire [7:0]     o_sel_rdata,
  input  wire           i_ctl_wr,
  input  wire [1:0]     i_ctl_port,
  input  wire [7:0]     i_ctl_wdata,
  output reg  [7:0]     o_ctl_rdata,
  input  wire [A_W-1:0] i_pa,
  output wire [A_W-1:0] o_pa,
  output wire [A_W-1:0] o_pa_oe_n,
  input  wire [B_W-1:0] i_pb,
  output wire [B_W-1:0] o_pb,
  output wire [B_W-1:0] o_pb_oe_n,
  input  wire [C_W-1:0] i_pc,
  output wire [C_W-1:0] o_pc,
  output wire [C_W-1:0] o_pc_oe_n,
  output wire [A_W-1:0] o_pa_ttl,
  output wire [B_W-1:0] o_pb_ttl,
  output wire [C_W-1:0] o_pc_ttl,
  output wire [A_W-1:0] o_pa_pullup_en,
  output wire [B_W-1:0] o_pb_pullup_en,
  output wire [C_W-1:0] o_pc_pullup_en,
  output wire [B_W-1:0] o_pb_schmitt_en,
  output wire [C_W-1:0] o_pc_schmitt_en,
  output wire [7:0]     o_comparator_control,
  output wire           o_wake_any
);
  reg  [7:0]     config_select_r;
  reg  [A_W-1:0] port_a_data_r;
  reg  [B_W-1:0] port_b_data_r;
  reg  [C_W-1:0] port_c_data_r;
  reg  [A_W-1:0] port_a_direction_r;
  reg  [B_W-1:0] port_b_direction_r;
  reg  [C_W-1:0] port_c_direction_r;
  reg  [A_W-1:0] port_a_threshold_r;
  reg  [B_W-1:0] port_b_threshold_r;
  reg  [C_W-1:0] port_c_threshold_r;
  reg  [A_W-1:0] port_a_pullup_off_r;
  reg  [B_W-1:0] port_b_pullup_off_r;
  reg  [C_W-1:0] port_c_pullup_off_r;
  reg  [B_W-1:0] port_b_hysteresis_off_r;
  reg  [C_W-1:0] port_c_hysteresis_off_r;
  reg  [7:0]     comparator_control_r;
  reg  [B_W-1:0] wake_edge_select_r;
  reg  [B_W-1:0] wake_enable_mask_r;
  reg  [B_W-1:0] wake_pending_flags_r;
  reg  [B_W-1:0] pb_prev_r;
  reg            pb_prev_ok_r;
  reg  [1:0]     pb_warm_r;
  wire [A_W-1:0] pa_s;
  wire [B_W-1:0] pb_s;
  wire [C_W-1:0] pc_s;
  wire [B_W-1:0] wake_hit;
  wire           ctl_a;
  wire           ctl_b;
  wire           ctl_c;
  wire           xchg_pend;

  // Pins are asynchronous, so every read path sees synchronised levels
  pin_sync #(.WIDTH(A_W)) u_sync_a (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_pa),
    .o_sync  (pa_s)
  );
  pin_sync #(.WIDTH(B_W)) u_sync_b (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_pb),
    .o_sync  (pb_s)
  );
  pin_sync #(.WIDTH(C_W)) u_sync_c (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_pc),
    .o_sync  (pc_s)
  );

  // Zero-extend a port sample to the 8-bit data path
  function [7:0] ext8;
    input [7:0] v;
    input integer w;
    integer k;
    begin
      ext8 = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        if (k < w)
          ext8[k] = v[k];
      end
    end
  endfunction

  assign ctl_a = i_ctl_wr && (i_ctl_port == `PORT_IDX_A);
  assign ctl_b = i_ctl_wr && (i_ctl_port == `PORT_IDX_B);
  assign ctl_c = i_ctl_wr && (i_ctl_port == `PORT_IDX_C);
  assign xchg_pend = ctl_b && (config_select_r == `SEL_WAKE_PENDING);

  // Selector register: own strobe, not on the data address map
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      config_select_r <= `SELECT_RESET; // RL13
    else if (i_sel_wr)
      config_select_r <= i_sel_wdata; // RL11 RL14
  end
  assign o_sel_rdata = config_select_r; // RL11

  // Output latches load regardless of direction
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_a_data_r <= {A_W{1'b0}};
      port_b_data_r <= {B_W{1'b0}};
      port_c_data_r <= {C_W{1'b0}};
    end else if (i_wr) begin
      if (i_addr == `ADDR_PORT_A)
        port_a_data_r <= i_wdata[A_W-1:0]; // RL2 RL4 RL6
      if (i_addr == `ADDR_PORT_B)
        port_b_data_r <= i_wdata[B_W-1:0]; // RL4 RL6
      if (i_addr == `ADDR_PORT_C)
        port_c_data_r <= i_wdata[C_W-1:0]; // RL4 RL6
    end
  end

  // Reads see pins, so a driven-high pin clamped low reads low
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_rd) begin
      case (i_addr)
        `ADDR_PORT_A: o_rdata <= ext8({4'h0, pa_s}, A_W); // RL2 RL7 RL8
        `ADDR_PORT_B: o_rdata <= ext8(pb_s, B_W); // RL7 RL8
        `ADDR_PORT_C: o_rdata <= ext8(pc_s, C_W); // RL7 RL8
        default:      o_rdata <= 8'h00;
      endcase
    end
  end

  // Port A control writes: only threshold, pullup, direction exist
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_a_direction_r  <= {A_W{1'b1}}; // RL3
      port_a_threshold_r  <= {A_W{1'b1}}; // RL3
      port_a_pullup_off_r <= {A_W{1'b1}}; // RL3
    end else if (ctl_a) begin
      case (config_select_r) // RL10 RL15
        `SEL_THRESHOLD: port_a_threshold_r  <= i_ctl_wdata[A_W-1:0];
        `SEL_PULLUP:    port_a_pullup_off_r <= i_ctl_wdata[A_W-1:0];
        `SEL_DIRECTION: port_a_direction_r  <= i_ctl_wdata[A_W-1:0];
        default:        port_a_direction_r  <= port_a_direction_r; // RL24
      endcase
    end
  end

  // Port B control writes cover every selector slot but 09h, the pending exchange below
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_b_direction_r      <= {B_W{1'b1}}; // RL3
      port_b_threshold_r      <= {B_W{1'b1}};
      port_b_pullup_off_r     <= {B_W{1'b1}};
      port_b_hysteresis_off_r <= {B_W{1'b1}};
      comparator_control_r    <= `CFG_RESET;
      wake_edge_select_r      <= {B_W{1'b1}};
      wake_enable_mask_r      <= {B_W{1'b1}};
    end else if (ctl_b) begin
      case (config_select_r) // RL10 RL15
        `SEL_COMPARATOR:   comparator_control_r    <= i_ctl_wdata;
        `SEL_WAKE_EDGE:    wake_edge_select_r      <= i_ctl_wdata[B_W-1:0];
        `SEL_WAKE_ENABLE:  wake_enable_mask_r      <= i_ctl_wdata[B_W-1:0];
        `SEL_HYSTERESIS:   port_b_hysteresis_off_r <= i_ctl_wdata[B_W-1:0];
        `SEL_THRESHOLD:    port_b_threshold_r      <= i_ctl_wdata[B_W-1:0];
        `SEL_PULLUP:       port_b_pullup_off_r     <= i_ctl_wdata[B_W-1:0];
        `SEL_DIRECTION:    port_b_direction_r      <= i_ctl_wdata[B_W-1:0];
        default:           port_b_direction_r      <= port_b_direction_r; // RL24
      endcase
    end
  end

  // Port C control writes: no comparator or wake slots
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port_c_direction_r      <= {C_W{1'b1}}; // RL3
      port_c_threshold_r      <= {C_W{1'b1}};
      port_c_pullup_off_r     <= {C_W{1'b1}};
      port_c_hysteresis_off_r <= {C_W{1'b1}};
    end else if (ctl_c) begin
      case (config_select_r) // RL10 RL15
        `SEL_HYSTERESIS: port_c_hysteresis_off_r <= i_ctl_wdata[C_W-1:0];
        `SEL_THRESHOLD:  port_c_threshold_r      <= i_ctl_wdata[C_W-1:0];
        `SEL_PULLUP:     port_c_pullup_off_r     <= i_ctl_wdata[C_W-1:0];
        `SEL_DIRECTION:  port_c_direction_r      <= i_ctl_wdata[C_W-1:0];
        default:         port_c_direction_r      <= port_c_direction_r; // RL24
      endcase
    end
  end

  // Edge detect waits until the synchroniser holds real samples, so the
  // synchroniser's reset zeros never look like a rising edge
  assign wake_hit = (~wake_enable_mask_r) & {B_W{pb_prev_ok_r}} &
                    ((~wake_edge_select_r & ~pb_prev_r & pb_s) |
                     (wake_edge_select_r & pb_prev_r & ~pb_s)); // RL21 RL22

  // Exchange with pending flags: a new edge in the same cycle wins
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pb_prev_r            <= {B_W{1'b0}};
      pb_prev_ok_r         <= 1'b0;
      pb_warm_r            <= 2'h0;
      wake_pending_flags_r <= {B_W{1'b0}};
    end else begin
      pb_prev_r    <= pb_s;
      pb_warm_r    <= {pb_warm_r[0], 1'b1};
      pb_prev_ok_r <= pb_warm_r[1];
      if (xchg_pend)
        wake_pending_flags_r <= i_ctl_wdata[B_W-1:0] | wake_hit;
      else
        wake_pending_flags_r <= wake_pending_flags_r | wake_hit; // RL23
    end
  end

  // Exchange slots return the old contents
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      o_ctl_rdata <= 8'h00;
    else if (ctl_b && config_select_r == `SEL_WAKE_PENDING)
      o_ctl_rdata <= ext8(wake_pending_flags_r, B_W); // RL23
    else if (ctl_b && config_select_r == `SEL_COMPARATOR)
      o_ctl_rdata <= comparator_control_r;
  end

  // Drivers: enable is low while driving
  assign o_pa      = port_a_data_r; // RL5
  assign o_pb      = port_b_data_r; // RL5
  assign o_pc      = port_c_data_r; // RL5
  assign o_pa_oe_n = port_a_direction_r; // RL17 RL1
  assign o_pb_oe_n = port_b_direction_r; // RL17
  assign o_pc_oe_n = port_c_direction_r; // RL17

  assign o_pa_ttl  = port_a_threshold_r; // RL18
  assign o_pb_ttl  = port_b_threshold_r; // RL18
  assign o_pc_ttl  = port_c_threshold_r; // RL18
  assign o_pa_pullup_en = ~port_a_pullup_off_r; // RL16
  assign o_pb_pullup_en = ~port_b_pullup_off_r; // RL16
  assign o_pc_pullup_en = ~port_c_pullup_off_r; // RL16
  // Port A has no hysteresis control at all
  assign o_pb_schmitt_en = ~port_b_hysteresis_off_r; // RL19 RL20
  assign o_pc_schmitt_en = ~port_c_hysteresis_off_r; // RL19 RL20
  // Comparator analog path lives outside; only its control byte is here
  assign o_comparator_control = comparator_control_r;
  assign o_wake_any = |wake_pending_flags_r;
endmodule // mode_selected_port_config

//--- src/port_cfg_regs.vh
// Register offsets, selector codes and reset values for the port block.
// Assumes inclusion by bare name from the design files.
`ifndef PORT_CFG_REGS_VH
`define PORT_CFG_REGS_VH
`define ADDR_PORT_A       5'h05
`define ADDR_PORT_B       5'h06
`define ADDR_PORT_C       5'h07
`define SEL_COMPARATOR    8'h08
`define SEL_WAKE_PENDING  8'h09
`define SEL_WAKE_EDGE     8'h0A
`define SEL_WAKE_ENABLE   8'h0B
`define SEL_HYSTERESIS    8'h0C
`define SEL_THRESHOLD     8'h0D
`define SEL_PULLUP        8'h0E
`define SEL_DIRECTION     8'h0F
`define SELECT_RESET      8'h0F
`define CFG_RESET         8'hFF
`define PORT_IDX_A        2'h0
`define PORT_IDX_B        2'h1
`define PORT_IDX_C        2'h2
`endif

//--- src/pin_sync.v
// Two-stage synchroniser for a bus of pin levels.
// Assumes the pins are asynchronous to i_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  // First stage feeds only the second stage
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule // pin_sync

//--- testbench/mode_selected_port_config_checker.sv
// Concurrent checks on the port block's top-level pins.
// Assumes binding into every instance of the block, one clock.
`timescale 1ns/1ps
module mode_selected_port_config_checker #(
  parameter A_W = 4,
  parameter B_W = 8,
  parameter C_W = 8
) (
  input wire           i_clk, i_rst, i_wr, i_rd, i_sel_wr, i_ctl_wr,
  input wire [4:0]     i_addr,
  input wire [1:0]     i_ctl_port,
  input wire [7:0]     i_wdata, i_sel_wdata, i_ctl_wdata, o_sel_rdata,
  input wire [7:0]     o_rdata,
  input wire [A_W-1:0] o_pa, o_pa_oe_n, o_pa_ttl, o_pa_pullup_en,
  input wire [B_W-1:0] o_pb_oe_n, o_pb_schmitt_en,
  input wire [C_W-1:0] o_pc_pullup_en,
  input wire           o_wake_any
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire ctl_b = i_ctl_wr && i_ctl_port == 2'h1;
  a_sel_reset_val: assert property ($fell(i_rst) |-> o_sel_rdata == 8'h0F)
    else $error("selector not 0Fh after reset");
  a_sel_load_val: assert property (i_sel_wr |=> o_sel_rdata == $past(i_sel_wdata))
    else $error("selector load lost");
  a_sel_value_holds: assert property (!i_sel_wr |=> $stable(o_sel_rdata))
    else $error("selector changed unasked");
  a_dir_b_write: assert property (ctl_b && o_sel_rdata == 8'h0F |=> o_pb_oe_n == $past(i_ctl_wdata))
    else $error("port b direction wrong");
  a_pullup_c_inv: assert property (i_ctl_wr && i_ctl_port == 2'h2 && o_sel_rdata == 8'h0E |=> o_pc_pullup_en == ~$past(i_ctl_wdata))
    else $error("port c pullup wrong");
  a_ttl_a_write: assert property (i_ctl_wr && i_ctl_port == 2'h0 && o_sel_rdata == 8'h0D |=> o_pa_ttl == $past(i_ctl_wdata[A_W-1:0]))
    else $error("port a threshold wrong");
  a_schmitt_b_inv: assert property (ctl_b && o_sel_rdata == 8'h0C |=> o_pb_schmitt_en == ~$past(i_ctl_wdata))
    else $error("port b schmitt wrong");
  a_unused_slot_a: assert property (i_ctl_wr && i_ctl_port == 2'h0 && o_sel_rdata < 8'h0D |=> $stable(o_pa_oe_n) && $stable(o_pa_ttl) && $stable(o_pa_pullup_en))
    else $error("unused slot changed port a");
  a_data_a_write: assert property (i_wr && i_addr == 5'h05 |=> o_pa == $past(i_wdata[A_W-1:0]))
    else $error("port a latch wrong");
  a_read_a_nibble: assert property (i_rd && i_addr == 5'h05 |=> o_rdata[7:4] == 4'h0)
    else $error("port a upper bits set");
  a_unmapped_read: assert property (i_rd && (i_addr < 5'h05 || i_addr > 5'h07) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_wake_swap: cover property (ctl_b && o_sel_rdata == 8'h09);
  c_wake_seen: cover property ($rose(o_wake_any));
  c_read_b: cover property (i_rd && i_addr == 5'h06);
endmodule // mode_selected_port_config_checker
bind mode_selected_port_config mode_selected_port_config_checker #(
  .A_W(A_W), .B_W(B_W), .C_W(C_W)) mode_selected_port_config_checker_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
  .i_sel_wr(i_sel_wr), .i_ctl_wr(i_ctl_wr), .i_addr(i_addr),
  .i_ctl_port(i_ctl_port), .i_wdata(i_wdata), .i_sel_wdata(i_sel_wdata),
  .i_ctl_wdata(i_ctl_wdata), .o_sel_rdata(o_sel_rdata), .o_rdata(o_rdata),
  .o_pa(o_pa), .o_pa_oe_n(o_pa_oe_n), .o_pa_ttl(o_pa_ttl),
  .o_pa_pullup_en(o_pa_pullup_en), .o_pb_oe_n(o_pb_oe_n),
  .o_pb_schmitt_en(o_pb_schmitt_en), .o_pc_pullup_en(o_pc_pullup_en),
  .o_wake_any(o_wake_any));

//--- testbench/pin_model.sv
// Board-side model of one port's pins: driver, pullup, outside source.
// Assumes oe_n low means the block drives the pin.
`timescale 1ns/1ps
module pin_model #(
  parameter W = 8
) (
  input  wire         i_clk,
  input  wire [W-1:0] i_oe_n, i_out, i_pull, i_ext_en, i_ext_val,
  output wire [W-1:0] o_pin
);
  reg wander_r = 1'b0;
  // Floating pins wander so a stale level is never read as valid
  always @(posedge i_clk) begin
    wander_r <= ~wander_r;
  end
  // Outside source wins over the driver, so a driven high can read low
  assign o_pin = (i_ext_en & i_ext_val) | (~i_ext_en & ((~i_oe_n & i_out)
                 | (i_oe_n & (i_pull | {W{wander_r}}))));
endmodule // pin_model

//--- testbench/mode_selected_port_config_tb.sv
// Self-checking bench for the port configuration block.
// Assumes pin models stand in for the board on every port.
`timescale 1ns/1ps
module mode_selected_port_config_tb;
  reg        i_clk = 1'b0, i_rst = 1'b1, note = 1'b0, seen = 1'b0;
  reg        i_wr = 1'b0, i_rd = 1'b0, i_sel_wr = 1'b0, i_ctl_wr = 1'b0;
  reg  [4:0] i_addr = 5'h00;
  reg  [1:0] i_ctl_port = 2'h0;
  reg  [7:0] i_wdata = 8'h00, i_sel_wdata = 8'h00, i_ctl_wdata = 8'h00;
  reg  [7:0] ext_en = 8'h00, ext_val = 8'h00, r;
  reg  [3:0] ext_a_en = 4'h0, ext_a_val = 4'h0;
  reg  [7:0] ext_c_en = 8'h00, ext_c_val = 8'h00;
  wire [7:0] o_rdata, o_sel_rdata, o_ctl_rdata, o_comparator_control;
  wire [3:0] pa, o_pa, o_pa_oe_n, o_pa_ttl, o_pa_pullup_en;
  wire [7:0] pb, o_pb, o_pb_oe_n, o_pb_pullup_en, o_pb_schmitt_en;
  wire [7:0] pc, o_pc, o_pc_oe_n, o_pc_pullup_en;
  wire       o_wake_any;
  int        miscompares = 0, num_checks = 0, seed = 73;
  logic [11:0] q[$];
  logic [11:0] nt;
  always #4 i_clk = ~i_clk;
  mode_selected_port_config mode_selected_port_config_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_sel_wr(i_sel_wr),
    .i_sel_wdata(i_sel_wdata), .o_sel_rdata(o_sel_rdata),
    .i_ctl_wr(i_ctl_wr), .i_ctl_port(i_ctl_port), .i_ctl_wdata(i_ctl_wdata),
    .o_ctl_rdata(o_ctl_rdata), .i_pa(pa), .o_pa(o_pa), .o_pa_oe_n(o_pa_oe_n),
    .i_pb(pb), .o_pb(o_pb), .o_pb_oe_n(o_pb_oe_n), .i_pc(pc), .o_pc(o_pc),
    .o_pc_oe_n(o_pc_oe_n), .o_pa_ttl(o_pa_ttl), .o_pb_ttl(), .o_pc_ttl(),
    .o_pa_pullup_en(o_pa_pullup_en), .o_pb_pullup_en(o_pb_pullup_en),
    .o_pc_pullup_en(o_pc_pullup_en), .o_pb_schmitt_en(o_pb_schmitt_en),
    .o_pc_schmitt_en(), .o_comparator_control(o_comparator_control),
    .o_wake_any(o_wake_any));
  pin_model #(.W(4)) pin_model_a_inst (.i_clk(i_clk), .i_oe_n(o_pa_oe_n),
    .i_out(o_pa), .i_pull(o_pa_pullup_en), .i_ext_en(ext_a_en),
    .i_ext_val(ext_a_val), .o_pin(pa));
  pin_model #(.W(8)) pin_model_b_inst (.i_clk(i_clk), .i_oe_n(o_pb_oe_n),
    .i_out(o_pb), .i_pull(o_pb_pullup_en), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_pin(pb));
  pin_model #(.W(8)) pin_model_c_inst (.i_clk(i_clk), .i_oe_n(o_pc_oe_n),
    .i_out(o_pc), .i_pull(o_pc_pullup_en), .i_ext_en(ext_c_en),
    .i_ext_val(ext_c_val), .o_pin(pc));
  task check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task stop_test;
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One strobe per edge: 1 write, 2 read, 3 selector, 4 control write
  task op(input [2:0] o, input [4:0] a, input [7:0] d,
          input [3:0] k = 4'h0, input [7:0] e = 8'h00, input n = 1'b0);
    @(posedge i_clk);
    i_wr <= (o == 3'h1);
    i_rd <= (o == 3'h2);
    i_sel_wr <= (o == 3'h3);
    i_ctl_wr <= (o == 3'h4);
    i_addr <= a;
    i_ctl_port <= a[1:0];
    i_wdata <= d;
    i_sel_wdata <= d;
    i_ctl_wdata <= d;
    note <= n;
    if (n) q.push_back({k, e});
  endtask
  // Pins need two edges of sync before a read sees them
  task rd(input [4:0] a, input [7:0] e);
    repeat (3) op(3'h0, 5'h00, 8'h00);
    op(3'h2, a, 8'h00, 4'h0, e, 1'b1);
  endtask
  always @(posedge i_clk) seen <= note;
  always @(negedge i_clk) begin
    if (seen) begin
      nt = q.pop_front();
      case (nt[11:8])
        4'h0: check("read data", o_rdata, nt[7:0]);
        4'h1: check("selector", o_sel_rdata, nt[7:0]);
        4'h2: check("exchange", o_ctl_rdata, nt[7:0]);
        4'h3: check("b direction", o_pb_oe_n, nt[7:0]);
        4'h4: check("b pullup", o_pb_pullup_en, nt[7:0]);
        4'h5: check("a threshold", {4'h0, o_pa_ttl}, nt[7:0]);
        4'h6: check("b schmitt", o_pb_schmitt_en, nt[7:0]);
        4'h7: check("comparator", o_comparator_control, nt[7:0]);
        4'h9: check("c direction", o_pc_oe_n, nt[7:0]);
        default: check("wake", {7'h00, o_wake_any}, nt[7:0]);
      endcase
    end
  end
  initial begin
    repeat (2000) @(posedge i_clk);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    op(0, 0, 0, 1, 8'h0F, 1);
    op(0, 0, 0, 3, 8'hFF, 1);
    op(0, 0, 0, 4, 8'h00, 1);
    op(0, 0, 0, 5, 8'h0F, 1);
    op(0, 0, 0, 6, 8'h00, 1);
    op(0, 0, 0, 7, 8'hFF, 1);
    op(4, 1, 8'hF0, 3, 8'hF0, 1);
    op(3, 0, 8'h0E, 1, 8'h0E, 1);
    op(4, 1, 8'h00, 4, 8'hFF, 1);
    op(3, 0, 8'h0F);
    op(1, 5'h06, 8'hA5);
    rd(5'h06, 8'hF5);
    op(4, 1, 8'h00, 3, 8'h00, 1);
    rd(5'h06, 8'hA5);
    ext_en <= 8'h01;
    rd(5'h06, 8'hA4);
    op(4, 0, 8'h00);
    op(1, 5'h05, 8'hF3);
    rd(5'h05, 8'h03);
    op(1, 5'h05, 8'h07);
    op(0, 0, 0);
    op(1, 5'h05, 8'h06);
    rd(5'h05, 8'h06);
    ext_a_en <= 4'h4;
    rd(5'h05, 8'h02);
    r = $random(seed);
    op(4, 2, 8'h00);
    op(1, 5'h07, r);
    rd(5'h07, r);
    ext_c_en <= 8'hFF;
    ext_c_val <= ~r;
    rd(5'h07, ~r);
    rd(5'h10, 8'h00);
    op(3, 0, 8'h0D);
    op(4, 0, 8'h0A, 5, 8'h0A, 1);
    op(4, 0, 8'h05, 5, 8'h05, 1);
    op(3, 0, 8'h0C);
    op(4, 0, 8'h00, 5, 8'h05, 1);
    op(4, 1, 8'h0F, 6, 8'hF0, 1);
    op(3, 0, 8'h08);
    op(4, 1, 8'h3C, 2, 8'hFF, 1);
    op(0, 0, 0, 7, 8'h3C, 1);
    op(3, 0, 8'h0B);
    op(4, 2, 8'hFF, 9, 8'h00, 1);
    op(3, 0, 8'h0F);
    op(4, 1, 8'h01);
    op(3, 0, 8'h0A);
    op(4, 1, 8'h00);
    op(3, 0, 8'h0B);
    op(4, 1, 8'hFE);
    repeat (3) op(0, 0, 0);
    op(0, 0, 0, 8, 8'h00, 1);
    ext_val <= 8'h01;
    repeat (5) op(0, 0, 0);
    op(0, 0, 0, 8, 8'h01, 1);
    op(3, 0, 8'h09);
    op(4, 1, 8'h00, 2, 8'h01, 1);
    op(0, 0, 0, 8, 8'h00, 1);
    op(0, 0, 0);
    op(0, 0, 0);
    stop_test;
  end
endmodule // mode_selected_port_config_tb
